// [core/uart_tx_consts.svh]
// Register addresses, reset values and field limits of the transmit unit
`ifndef UART_TX_CONSTS_SVH
`define UART_TX_CONSTS_SVH
`define TX_STATUS_ADDR 16'hff55
`define BASE_SEL_ADDR 16'hff56
`define BAUD_DIV_ADDR 16'hff57
`define TX_STATUS_RST 8'h00
`define BASE_SEL_RST 8'h00
`define BAUD_DIV_RST 8'hff
`define BASE_SEL_W 4
`define BASE_CODE_MAX_DIV 4'ha
`define BASE_CODE_TIMER 4'hb
`define PRESCALE_W 10
`define DIV_K_MIN 8'h08
`define DATA_BITS 4'h8
`define POWER_START_TICKS 2'h2
`define FLAG_SHIFT_BUSY 0
`define FLAG_BUF_FULL 1
`endif

// [core/uart_tx_pkg.sv]
// Types shared by the transmit-status and baud generator block
package uart_tx_pkg;
    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_START = 4'b0010,
        TX_DATA = 4'b0100,
        TX_STOP = 4'b1000
    } tx_state_t;
endpackage

// [core/fifo_if.sv]
// Valid/ready byte stream carrier between the block's modules
`timescale 1ns/10ps
interface fifo_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;
    modport source (output data, output valid, input ready);
    modport sink (input data, input valid, output ready);
endinterface

// [core/tx_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module tx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic flush,
    fifo_if.sink fill,
    fifo_if.source drain
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic doWrite;
    logic doRead;

    // Handshakes
    assign fill.ready = (count != DEPTH_C);
    assign drain.valid = (count != '0);
    assign drain.data = mem[rdPtr];
    assign doWrite = fill.valid && fill.ready;
    assign doRead = drain.valid && drain.ready;

    // Storage
    always_ff @(posedge clk)
    begin
        if (doWrite)
        begin
            mem[wrPtr] <= fill.data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end
        else if (flush)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end
        else
        begin
            if (doWrite)
            begin
                wrPtr <= (wrPtr == LAST_C) ? '0 : wrPtr + 1'b1;
            end
            if (doRead)
            begin
                rdPtr <= (rdPtr == LAST_C) ? '0 : rdPtr + 1'b1;
            end
            if (doWrite && !doRead)
            begin
                count <= count + 1'b1;
            end
            else if (doRead && !doWrite)
            begin
                count <= count - 1'b1;
            end
        end
    end

    a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_b)
        (count == DEPTH_C) |-> !fill.ready)
        else $error("fifo accepts data while full");
endmodule

// [core/uart_tx_status_baud_gen.sv]
// Transmit status flags, baud generator and byte transmitter
//
// Functional notes
// - Buffer-full sets on write, clears on transfer
// - Shift-busy sets on transfer, clears when idle
// - Status clears on reset, power off, disable
// - Status read-only, flags bits 1:0, upper zero
// - New byte accepted right after transfer
// - Codes 0-10 select system clock over 2^n
// - Code 11 selects timer output; above prohibited
// - Base select resets to zero, byte writes
// - Eight-bit divider by k, 8 to 255
// - Bit rate is counter output halved
// - Divider resets to all ones, byte writes
// - Same-value rewrites never disturb communication
// - Power off resets; counter starts third tick
`timescale 1ns/10ps
`include "uart_tx_consts.svh"
module uart_tx_status_baud_gen #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [15:0] busAddr,
    input wire logic [7:0] busWrData,
    input wire logic busWr,
    input wire logic busRd,
    output logic [7:0] busRdData,
    input wire logic unitPowerBit,
    input wire logic txEnableBit,
    input wire logic rxEnableBit,
    input wire logic timerOutput,
    input wire logic [7:0] txData,
    input wire logic txValid,
    output logic txReady,
    output logic txd,
    output logic txDone
);
    // ==========================================================
    // Registers and bus
    // ==========================================================
    logic [`BASE_SEL_W-1:0] baseCode;
    logic [7:0] divK;
    logic txBufFull;
    logic txBusy;
    logic [7:0] holdBuf;
    logic [7:0] txStatus;
    logic txOn;
    logic transferNow;

    assign txOn = unitPowerBit && txEnableBit;
    assign txStatus = {6'h00, txBufFull, txBusy};

    // Base clock select; whole byte write, same value is harmless
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            baseCode <= `BASE_SEL_W'(`BASE_SEL_RST);
        end
        else if (busWr && busAddr == `BASE_SEL_ADDR)
        begin
            baseCode <= busWrData[`BASE_SEL_W-1:0];
        end
    end

    // Divider value; whole byte write, same value is harmless
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            divK <= `BAUD_DIV_RST;
        end
        else if (busWr && busAddr == `BAUD_DIV_ADDR)
        begin
            divK <= busWrData;
        end
    end

    // Registered read data; unmapped addresses read zero
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            busRdData <= 8'h00;
        end
        else if (busRd)
        begin
            case (busAddr)
                `TX_STATUS_ADDR: busRdData <= txStatus;
                `BASE_SEL_ADDR: busRdData <= {4'h0, baseCode};
                `BAUD_DIV_ADDR: busRdData <= divK;
                default: busRdData <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Base clock selection
    // ==========================================================
    logic [`PRESCALE_W-1:0] prescale;
    logic [`PRESCALE_W-1:0] prescaleMask;
    logic timerPrev;
    logic baseTick;

    // Free-running power-of-two prescaler on the system clock
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prescale <= '0;
        end
        else if (!unitPowerBit)
        begin
            prescale <= '0;
        end
        else
        begin
            prescale <= prescale + 1'b1;
        end
    end

    // Timer output edge detect, same clock domain
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            timerPrev <= 1'b0;
        end
        else
        begin
            timerPrev <= timerOutput;
        end
    end

    // Base tick from prescaler code, timer or nothing
    always_comb
    begin
        prescaleMask = ~({`PRESCALE_W{1'b1}} << baseCode);
        if (!unitPowerBit)
        begin
            baseTick = 1'b0;
        end
        else if (baseCode <= `BASE_CODE_MAX_DIV)
        begin
            baseTick = (prescale & prescaleMask) == prescaleMask;
        end
        else if (baseCode == `BASE_CODE_TIMER)
        begin
            baseTick = timerOutput && !timerPrev;
        end
        else
        begin
            baseTick = 1'b0;
        end
    end

    // ==========================================================
    // Eight-bit divider and bit rate
    // ==========================================================
    logic [1:0] powerTicks;
    logic divRun;
    logic [7:0] divCount;
    logic counterOut;
    logic bitHalf;
    logic bitTick;

    assign divRun = (powerTicks == `POWER_START_TICKS);
    assign counterOut = divRun && baseTick && (divCount >= divK - 8'h01);
    assign bitTick = counterOut && bitHalf;

    // Counter output held off for the first two base ticks, counting from the third
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            powerTicks <= 2'h0;
        end
        else if (!unitPowerBit)
        begin
            powerTicks <= 2'h0;
        end
        else if (baseTick && !divRun)
        begin
            powerTicks <= powerTicks + 2'h1;
        end
    end

    // Divide the base clock by k
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            divCount <= 8'h00;
        end
        else if (!unitPowerBit)
        begin
            divCount <= 8'h00;
        end
        else if (divRun && baseTick)
        begin
            divCount <= counterOut ? 8'h00 : divCount + 8'h01;
        end
    end

    // Halve the counter output to get the bit period
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bitHalf <= 1'b0;
        end
        else if (!unitPowerBit)
        begin
            bitHalf <= 1'b0;
        end
        else if (counterOut)
        begin
            bitHalf <= !bitHalf;
        end
    end

    // ==========================================================
    // Input FIFO and holding buffer
    // ==========================================================
    fifo_if #(.WIDTH(8)) fillIf ();
    fifo_if #(.WIDTH(8)) drainIf ();
    logic holdLoad;

    assign fillIf.data = txData;
    assign fillIf.valid = txValid && txOn;
    assign txReady = fillIf.ready && txOn;
    assign holdLoad = drainIf.valid && drainIf.ready;
    assign drainIf.ready = txOn && (!txBufFull || transferNow);

    tx_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) inFifo (
        .clk(clk),
        .rst_b(rst_b),
        .flush(!txOn),
        .fill(fillIf.sink),
        .drain(drainIf.source)
    );

    // Holding buffer data
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            holdBuf <= 8'h00;
        end
        else if (holdLoad)
        begin
            holdBuf <= drainIf.data;
        end
    end

    // Buffer-full flag; a load in the transfer cycle keeps it set
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            txBufFull <= 1'b0;
        end
        else if (!txOn)
        begin
            txBufFull <= 1'b0;
        end
        else if (holdLoad)
        begin
            txBufFull <= 1'b1;
        end
        else if (transferNow)
        begin
            txBufFull <= 1'b0;
        end
    end

    // ==========================================================
    // Shift register and line
    // ==========================================================
    uart_tx_pkg::tx_state_t state;
    logic [7:0] shiftReg;
    logic [3:0] bitCount;
    logic lastStop;

    assign lastStop = (state == uart_tx_pkg::TX_STOP) && bitTick;
    assign transferNow = txOn && txBufFull && bitTick
        && (state == uart_tx_pkg::TX_IDLE || lastStop);

    // Frame sequencing, one bit per bit tick
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= uart_tx_pkg::TX_IDLE;
            shiftReg <= 8'h00;
            bitCount <= 4'h0;
        end
        else if (!txOn)
        begin
            state <= uart_tx_pkg::TX_IDLE;
            bitCount <= 4'h0;
        end
        else if (transferNow)
        begin
            state <= uart_tx_pkg::TX_START;
            shiftReg <= holdBuf;
            bitCount <= 4'h0;
        end
        else if (bitTick)
        begin
            case (state)
                uart_tx_pkg::TX_START: state <= uart_tx_pkg::TX_DATA;
                uart_tx_pkg::TX_DATA:
                begin
                    shiftReg <= {1'b0, shiftReg[7:1]};
                    bitCount <= bitCount + 4'h1;
                    if (bitCount == `DATA_BITS - 4'h1)
                    begin
                        state <= uart_tx_pkg::TX_STOP;
                    end
                end
                uart_tx_pkg::TX_STOP: state <= uart_tx_pkg::TX_IDLE;
                default: state <= uart_tx_pkg::TX_IDLE;
            endcase
        end
    end

    // Line level; idles high
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            txd <= 1'b1;
        end
        else
        begin
            case (state)
                uart_tx_pkg::TX_START: txd <= 1'b0;
                uart_tx_pkg::TX_DATA: txd <= shiftReg[0];
                default: txd <= 1'b1;
            endcase
        end
    end

    // Shift-busy flag and completion pulse
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            txBusy <= 1'b0;
            txDone <= 1'b0;
        end
        else if (!txOn)
        begin
            txBusy <= 1'b0;
            txDone <= 1'b0;
        end
        else if (transferNow)
        begin
            txBusy <= 1'b1;
            txDone <= 1'b0;
        end
        else if (lastStop)
        begin
            txBusy <= 1'b0;
            txDone <= 1'b1;
        end
        else
        begin
            txDone <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    a_buf_set: assert property (@(posedge clk) disable iff (!rst_b)
        (txOn && holdLoad) ##1 txOn |-> txBufFull)
        else $error("buffer-full not set after load");
    a_busy_set: assert property (@(posedge clk) disable iff (!rst_b)
        (transferNow ##1 txOn) |-> (txBusy && state == uart_tx_pkg::TX_START))
        else $error("busy not set after transfer");
    a_status_clear: assert property (@(posedge clk) disable iff (!rst_b)
        !txOn |=> (txStatus == `TX_STATUS_RST) || txOn)
        else $error("status not cleared while disabled");
    a_status_read: assert property (@(posedge clk) disable iff (!rst_b)
        (busRd && busAddr == `TX_STATUS_ADDR) |=>
        (busRdData == {6'h00, $past(txBufFull), $past(txBusy)}))
        else $error("status read value wrong");
    a_base_code0: assert property (@(posedge clk) disable iff (!rst_b)
        (unitPowerBit && baseCode == 4'h0) |-> baseTick)
        else $error("code zero must tick every cycle");
    a_base_prohib: assert property (@(posedge clk) disable iff (!rst_b)
        (baseCode > `BASE_CODE_TIMER) |-> !baseTick)
        else $error("prohibited code produced a base tick");
    a_div_wrap: assert property (@(posedge clk) disable iff (!rst_b)
        counterOut |=> (divCount == 8'h00))
        else $error("divider did not wrap on output");
    a_bit_half: assert property (@(posedge clk) disable iff (!rst_b)
        bitTick |-> (counterOut && $past(bitHalf) == bitHalf))
        else $error("bit tick not on alternate counter output");
    a_power_hold: assert property (@(posedge clk) disable iff (!rst_b)
        !unitPowerBit |=> (divCount == 8'h00 && !counterOut) || unitPowerBit)
        else $error("divider runs while power is off");
    a_done_idle: assert property (@(posedge clk) disable iff (!rst_b)
        txDone |-> (!txBusy && !$past(txBufFull)
        && state == uart_tx_pkg::TX_IDLE))
        else $error("completion while data remains");
endmodule

// [verif/uart_far_node.sv]
// Remote serial node that receives frames from the transmit line
`timescale 1ns/10ps
module uart_far_node (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic txd,
    input wire logic [15:0] bitClocks,
    output logic [7:0] rxByte,
    output logic [15:0] frameCount,
    output logic [15:0] frameGap,
    output logic stopBad
);
    time lastStart;
    // ====================================================
    // Frame receiver
    // Detects the start edge and samples each bit in its middle
    initial
    begin
        rxByte = 8'h00;
        frameCount = 16'h0000;
        frameGap = 16'h0000;
        stopBad = 1'b0;
        lastStart = 0;
        forever
        begin
            @(posedge clk);
            if (rst_b === 1'b1 && txd === 1'b0)
            begin
                frameGap = 16'(($time - lastStart) / 5); // Cycles between starts
                lastStart = $time;
                repeat (bitClocks / 2) @(posedge clk);
                if (txd !== 1'b0)
                    stopBad = 1'b1; // Start bit must still be low
                for (int i = 0; i < 8; i++)
                begin
                    repeat (bitClocks) @(posedge clk);
                    rxByte[i] = txd; // Least significant bit first
                end
                repeat (bitClocks) @(posedge clk);
                if (txd !== 1'b1)
                    stopBad = 1'b1; // Stop bit must be high
                frameCount = frameCount + 16'h0001;
            end
        end
    end
endmodule

// [verif/tb_uart_tx_status_baud_gen.sv]
// Self-checking bench for the transmit status and baud generator block
`timescale 1ns/10ps
`include "uart_tx_consts.svh"
module tb_uart_tx_status_baud_gen;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] busAddr = 16'h0000;
    logic [7:0] busWrData = 8'h00;
    logic busWr = 1'b0;
    logic busRd = 1'b0;
    logic unitPowerBit = 1'b0;
    logic txEnableBit = 1'b0;
    logic rxEnableBit = 1'b0;
    logic timerOutput = 1'b0;
    logic [7:0] txData = 8'h00;
    logic txValid = 1'b0;
    logic [7:0] busRdData;
    logic txReady;
    logic txd;
    logic txDone;
    logic [15:0] bitClocks = 16'h0010;
    logic [7:0] rxByte;
    logic [15:0] frameCount;
    logic [15:0] frameGap;
    logic stopBad;
    logic [1:0] timerPhase = 2'h0;
    logic [7:0] doneCount = 8'h00;
    logic [7:0] rd;
    logic [15:0] fc;
    logic [7:0] dc;
    logic [3:0] cfgCode [5] = '{4'h0, 4'h1, 4'h0, 4'hb, 4'h3};
    logic [7:0] cfgK [5] = '{8'h08, 8'h08, 8'h09, 8'h08, 8'h08};
    logic [15:0] cfgBits [5] = '{16'h0010, 16'h0020, 16'h0012, 16'h0040,
        16'h0080};
    int err_total = 0;
    int cmp_count = 0;
    int cycles = 0;
    int acc;
    // ====================================================
    // Clock, timer source and watchdogs
    always #2.5 clk = ~clk;
    // Timer runs before it is selected, half duty, rising every four clocks
    always @(posedge clk)
    begin
        timerPhase <= timerPhase + 2'h1;
        timerOutput <= timerPhase[1];
        if (txDone === 1'b1)
            doneCount <= doneCount + 8'h01;
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            err_total = err_total + 1;
            report_and_stop();
        end
    end
    // ====================================================
    // Design and far node
    uart_tx_status_baud_gen #(.FIFO_DEPTH(4)) DUT (
        .clk(clk), .rst_b(rst_b), .busAddr(busAddr), .busWrData(busWrData),
        .busWr(busWr), .busRd(busRd), .busRdData(busRdData),
        .unitPowerBit(unitPowerBit), .txEnableBit(txEnableBit),
        .rxEnableBit(rxEnableBit), .timerOutput(timerOutput),
        .txData(txData), .txValid(txValid), .txReady(txReady),
        .txd(txd), .txDone(txDone)
    );
    uart_far_node far (
        .clk(clk), .rst_b(rst_b), .txd(txd), .bitClocks(bitClocks),
        .rxByte(rxByte), .frameCount(frameCount), .frameGap(frameGap),
        .stopBad(stopBad)
    );
    // ====================================================
    // Tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp)
        begin
            err_total = err_total + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        busAddr <= a;
        busWrData <= d;
        busWr <= 1'b1;
        @(posedge clk);
        busWr <= 1'b0;
    endtask
    task automatic rdReg(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        busAddr <= a;
        busRd <= 1'b1;
        @(posedge clk);
        busRd <= 1'b0;
        #1 d = busRdData; // Registered answer one cycle on
    endtask
    task automatic send(input logic [7:0] d);
        @(posedge clk);
        txData <= d;
        txValid <= 1'b1;
        @(negedge clk);
        while (txReady !== 1'b1)
            @(negedge clk);
        @(posedge clk);
        txValid <= 1'b0;
    endtask
    task automatic waitFrames(input logic [15:0] target);
        for (int n = 0; n < 5000 && frameCount < target; n++)
            @(posedge clk);
    endtask
    task automatic setup(input logic [3:0] code, input logic [7:0] k);
        @(posedge clk);
        txEnableBit <= 1'b0;
        unitPowerBit <= 1'b0;
        wr(`BASE_SEL_ADDR, {4'h0, code});
        wr(`BAUD_DIV_ADDR, k);
        @(posedge clk);
        unitPowerBit <= 1'b1;
        @(posedge clk);
        txEnableBit <= 1'b1;
    endtask
    task automatic report_and_stop();
        if (err_total == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ====================================================
    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        rdReg(`TX_STATUS_ADDR, rd);
        check({8'h00, rd}, 16'h0000);
        rdReg(`BASE_SEL_ADDR, rd);
        check({8'h00, rd}, 16'h0000);
        rdReg(`BAUD_DIV_ADDR, rd);
        check({8'h00, rd}, 16'h00ff);
        rdReg(16'hff58, rd);
        check({8'h00, rd}, 16'h0000); // Unmapped place
        wr(`BASE_SEL_ADDR, 8'hf1);
        rdReg(`BASE_SEL_ADDR, rd);
        check({8'h00, rd}, 16'h0001);
        wr(`TX_STATUS_ADDR, 8'hff);
        rdReg(`TX_STATUS_ADDR, rd);
        check({8'h00, rd}, 16'h0000);
        // Two back-to-back bytes for each clock setting
        for (int i = 0; i < 5; i++)
        begin
            setup(cfgCode[i], cfgK[i]);
            bitClocks <= cfgBits[i];
            fc = frameCount;
            dc = doneCount;
            send(8'h5a ^ 8'(i));
            send(8'hc3);
            // First byte moves on at the first bit tick; wait for it
            rd = 8'h00;
            for (int n = 0; n < 300 && rd[`FLAG_SHIFT_BUSY] !== 1'b1; n++)
                rdReg(`TX_STATUS_ADDR, rd);
            check({8'h00, rd}, 16'h0003);
            wr(`BAUD_DIV_ADDR, cfgK[i]);
            wr(`BASE_SEL_ADDR, {4'h0, cfgCode[i]});
            rdReg(`TX_STATUS_ADDR, rd);
            check({15'h0000, rd[`FLAG_SHIFT_BUSY]}, 16'h0001);
            waitFrames(fc + 16'h0001);
            check({8'h00, rxByte}, {8'h00, 8'h5a ^ 8'(i)});
            waitFrames(fc + 16'h0002);
            check({8'h00, rxByte}, 16'h00c3);
            check(frameGap, 16'h000a * cfgBits[i]);
            rd = 8'hff;
            for (int n = 0; n < 300 && rd !== 8'h00; n++)
                rdReg(`TX_STATUS_ADDR, rd);
            check({8'h00, rd}, 16'h0000);
            repeat (2) @(posedge clk);
            check({8'h00, doneCount - dc}, 16'h0001);
        end
        check({15'h0000, stopBad}, 16'h0000);
        // Prohibited code gives no ticks: FIFO and buffer fill up
        setup(4'hc, 8'h08);
        fc = frameCount;
        @(posedge clk);
        txData <= 8'h11;
        txValid <= 1'b1;
        acc = 0;
        repeat (20)
        begin
            @(negedge clk);
            if (txReady === 1'b1)
                acc++;
        end
        @(posedge clk);
        txValid <= 1'b0;
        check(16'(acc), 16'h0005);
        rdReg(`TX_STATUS_ADDR, rd);
        check({8'h00, rd}, 16'h0002);
        check(frameCount, fc);
        check({15'h0000, txd}, 16'h0001);
        // Disabling transmit mid-frame clears the status
        setup(4'h0, 8'h08);
        send(8'h96);
        repeat (60) @(posedge clk);
        rdReg(`TX_STATUS_ADDR, rd);
        check({8'h00, rd}, 16'h0001);
        @(posedge clk);
        txEnableBit <= 1'b0;
        repeat (2) @(posedge clk);
        rdReg(`TX_STATUS_ADDR, rd);
        check({8'h00, rd}, 16'h0000);
        report_and_stop();
    end
endmodule
